// file: logic/ptd_divider.sv
// programmable tone divider: source pick, prescaler, reload counter, tone pin
//
// How it works
// - control bits 3..0 always read zero
// - enable bit drives tone; off holds pin low
// - bits 6,5 prescale by 1,2,4,8
// - bit 7 picks fast/4 or 32768 Hz source
// - 8-bit count register sets division value
// - count writes ignored while divider disabled
// - disabled divider clears count register
// - tone equals prescaler output over 2(N+1)
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ns

module ptd_divider #(
	parameter int CLK_HZ = ptd_pkg::PTD_CLK_HZ
) (
	input  wire logic                            clk,
	input  wire logic                            arst_n,
	input  wire ptd_pkg::ptd_bus_req_s           bus_req,
	output logic [ptd_pkg::PTD_DATA_W-1:0]       bus_rdata,
	output logic                                 tone_output_pin
);
	import ptd_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// elaboration checks: both sources need at least two clocks per period
	if (CLK_HZ < 2 * PTD_FAST_SRC_HZ) begin : g_bad_clk
		$error("clock rate too low for the fast tone source");
	end
	if (CLK_HZ >= 2 ** (PTD_PHASE_W - 2)) begin : g_bad_phase
		$error("clock rate too high for the phase accumulators");
	end

	localparam logic [PTD_PHASE_W-1:0] MODULUS  = PTD_PHASE_W'(CLK_HZ);
	localparam logic [PTD_PHASE_W-1:0] FAST_INC = PTD_PHASE_W'(PTD_FAST_SRC_HZ);
	localparam logic [PTD_PHASE_W-1:0] SLOW_INC = PTD_PHASE_W'(PTD_SLOW_SRC_HZ);

	ptd_ctrl_s                   ctrl;
	logic [7:0]                  count_value;
	logic [PTD_PHASE_W-1:0]      fast_phase;
	logic [PTD_PHASE_W-1:0]      slow_phase;
	logic [PTD_PHASE_W-1:0]      next_fast_phase;
	logic [PTD_PHASE_W-1:0]      next_slow_phase;
	logic                        fast_tick;
	logic                        slow_tick;
	logic                        src_tick;
	logic [PTD_PRESCALE_W-1:0]   presc_cnt;
	logic [PTD_PRESCALE_W-1:0]   presc_mask;
	logic                        pres_tick;
	logic [7:0]                  gen_cnt;
	logic                        reload;
	logic                        wr_ctrl;
	logic                        wr_count;
	logic                        rd_ctrl;
	logic                        rd_count;

	////////////////////////////////////////////////////////////////////////////
	// register port decode
	assign wr_ctrl  = bus_req.wr && (bus_req.addr == PTD_ADDR_DIVIDER_CONTROL);
	assign wr_count = bus_req.wr && (bus_req.addr == PTD_ADDR_DIVIDER_COUNT_VALUE);
	assign rd_ctrl  = bus_req.rd && (bus_req.addr == PTD_ADDR_DIVIDER_CONTROL);
	assign rd_count = bus_req.rd && (bus_req.addr == PTD_ADDR_DIVIDER_COUNT_VALUE);

	// control nibble, only the upper four bits are stored
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl <= ptd_ctrl_s'(PTD_CTRL_RESET);
		end else if (wr_ctrl) begin
			ctrl <= ptd_ctrl_s'(bus_req.wdata[7:PTD_CTRL_LSB]);
		end
	end

	// count value: blocked and held at zero while the divider is off
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			count_value <= PTD_COUNT_RESET;
		end else if (!ctrl.tone_output_enable) begin
			count_value <= PTD_COUNT_RESET;
		end else if (wr_ctrl && !bus_req.wdata[PTD_BIT_TONE_OUTPUT_ENABLE]) begin
			count_value <= PTD_COUNT_RESET;
		end else if (wr_count) begin
			count_value <= bus_req.wdata;
		end
	end

	// read data stands only in the cycle after the read strobe
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			bus_rdata <= '0;
		end else if (rd_ctrl) begin
			bus_rdata <= {ctrl, PTD_CTRL_UNUSED_READ};
		end else if (rd_count) begin
			bus_rdata <= count_value;
		end else begin
			bus_rdata <= '0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// source ticks: phase accumulators give exact average rates from clk
	always_comb begin
		next_fast_phase = fast_phase + FAST_INC;
		next_slow_phase = slow_phase + SLOW_INC;
	end

	assign fast_tick = (next_fast_phase >= MODULUS);
	assign slow_tick = (next_slow_phase >= MODULUS);

	// fast source accumulator
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			fast_phase <= '0;
		end else if (fast_tick) begin
			fast_phase <= next_fast_phase - MODULUS;
		end else begin
			fast_phase <= next_fast_phase;
		end
	end

	// slow source accumulator
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			slow_phase <= '0;
		end else if (slow_tick) begin
			slow_phase <= next_slow_phase - MODULUS;
		end else begin
			slow_phase <= next_slow_phase;
		end
	end

	// source pick
	assign src_tick = ctrl.source_clock_select ? fast_tick : slow_tick;

	////////////////////////////////////////////////////////////////////////////
	// prescaler: a tick leaves when the masked low bits are all ones
	always_comb begin
		case (ctrl.prescale_select)
			PTD_PRES_DIV1: presc_mask = 3'h0;
			PTD_PRES_DIV2: presc_mask = 3'h1;
			PTD_PRES_DIV4: presc_mask = 3'h3;
			PTD_PRES_DIV8: presc_mask = 3'h7;
			default:       presc_mask = 3'h0;
		endcase
	end

	assign pres_tick = src_tick && ((presc_cnt & presc_mask) == presc_mask);

	// prescaler counter, held at zero while disabled
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			presc_cnt <= '0;
		end else if (!ctrl.tone_output_enable) begin
			presc_cnt <= '0;
		end else if (src_tick) begin
			presc_cnt <= presc_cnt + 3'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// general counter: counts down from N, reload after N+1 prescaler ticks
	assign reload = pres_tick && (gen_cnt == 8'h00);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			gen_cnt <= 8'h00;
		end else if (!ctrl.tone_output_enable) begin
			gen_cnt <= 8'h00;
		end else if (reload) begin
			gen_cnt <= count_value;
		end else if (pres_tick) begin
			gen_cnt <= gen_cnt - 8'h01;
		end
	end

	// tone flop: toggles on each reload, low whenever disabled
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tone_output_pin <= 1'b0;
		end else if (!ctrl.tone_output_enable) begin
			tone_output_pin <= 1'b0;
		end else if (reload) begin
			tone_output_pin <= !tone_output_pin;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// assertions
	chk_unused_reads_zero: assert property (
		@(posedge clk) disable iff (!arst_n)
		rd_ctrl |=> (bus_rdata[3:0] == 4'h0)
	) else $error("unused control bits read non-zero");

	chk_off_pin_low: assert property (
		@(posedge clk) disable iff (!arst_n)
		(!ctrl.tone_output_enable && !wr_ctrl) |=> !tone_output_pin [*2]
	) else $error("tone pin not low while divider is off");

	chk_prescale_ratio: assert property (
		@(posedge clk) disable iff (!arst_n)
		pres_tick |-> src_tick
			&& (ctrl.prescale_select != PTD_PRES_DIV2 || presc_cnt[0])
			&& (ctrl.prescale_select != PTD_PRES_DIV4 || presc_cnt[1:0] == 2'h3)
			&& (ctrl.prescale_select != PTD_PRES_DIV8 || presc_cnt == 3'h7)
	) else $error("prescaler tick off its ratio");

	chk_div8_spacing: assert property (
		@(posedge clk) disable iff (!arst_n)
		(pres_tick && ctrl.prescale_select == PTD_PRES_DIV8
			&& ctrl.tone_output_enable)
		|=> (!pres_tick || ctrl.prescale_select != PTD_PRES_DIV8) [*8]
	) else $error("divide-by-eight prescaler ticked too soon");

	chk_slow_source: assert property (
		@(posedge clk) disable iff (!arst_n)
		(src_tick && !ctrl.source_clock_select) |-> slow_tick
	) else $error("slow source not selected");

	chk_count_write: assert property (
		@(posedge clk) disable iff (!arst_n)
		(wr_count && ctrl.tone_output_enable)
		|=> (count_value == $past(bus_req.wdata))
	) else $error("count write not stored while enabled");

	chk_write_blocked: assert property (
		@(posedge clk) disable iff (!arst_n)
		(wr_count && !ctrl.tone_output_enable) |=> (count_value == 8'h00)
	) else $error("count write taken while disabled");

	chk_off_clears_count: assert property (
		@(posedge clk) disable iff (!arst_n)
		(wr_ctrl && !bus_req.wdata[PTD_BIT_TONE_OUTPUT_ENABLE])
		|=> (count_value == 8'h00) [*2]
	) else $error("count not cleared on disable");

	chk_tone_toggles: assert property (
		@(posedge clk) disable iff (!arst_n)
		(reload && ctrl.tone_output_enable && !wr_ctrl)
		|=> (tone_output_pin != $past(tone_output_pin))
	) else $error("tone did not toggle on reload");

	chk_tone_steady: assert property (
		@(posedge clk) disable iff (!arst_n)
		(!reload && ctrl.tone_output_enable && !wr_ctrl) |=> $stable(tone_output_pin)
	) else $error("tone changed between reloads");

	chk_reload_value: assert property (
		@(posedge clk) disable iff (!arst_n)
		(reload && ctrl.tone_output_enable && !wr_ctrl)
		|=> (gen_cnt == $past(count_value))
	) else $error("counter did not reload the count value");

	// main scenarios
	cov_fast_div8: cover property (
		@(posedge clk) disable iff (!arst_n)
		reload && ctrl.source_clock_select && ctrl.prescale_select == PTD_PRES_DIV8
	);

	cov_slow_toggle: cover property (
		@(posedge clk) disable iff (!arst_n)
		reload && !ctrl.source_clock_select && tone_output_pin
	);

	cov_blocked_write: cover property (
		@(posedge clk) disable iff (!arst_n)
		wr_count && !ctrl.tone_output_enable
	);

	cov_disable_running: cover property (
		@(posedge clk) disable iff (!arst_n)
		tone_output_pin ##1 !ctrl.tone_output_enable
	);

endmodule : ptd_divider

// file: pkg/ptd_pkg.sv
// shared constants and types for the programmable tone divider
package ptd_pkg;

	////////////////////////////////////////////////////////////////////////////
	// register map, byte addresses on the plain register port
	localparam logic [7:0] PTD_ADDR_DIVIDER_CONTROL     = 8'h2e;
	localparam logic [7:0] PTD_ADDR_DIVIDER_COUNT_VALUE = 8'h2f;
	localparam int         PTD_ADDR_W                   = 8;
	localparam int         PTD_DATA_W                   = 8;

	////////////////////////////////////////////////////////////////////////////
	// divider_control field positions
	localparam int PTD_BIT_TONE_OUTPUT_ENABLE   = 4;
	localparam int PTD_BIT_PRESCALE_SELECT_LOW  = 5;
	localparam int PTD_BIT_PRESCALE_SELECT_HIGH = 6;
	localparam int PTD_BIT_SOURCE_CLOCK_SELECT  = 7;
	localparam int PTD_CTRL_LSB                 = 4;
	localparam logic [3:0] PTD_CTRL_UNUSED_READ = 4'h0;

	////////////////////////////////////////////////////////////////////////////
	// reset values
	localparam logic [3:0] PTD_CTRL_RESET  = 4'h0;
	localparam logic [7:0] PTD_COUNT_RESET = 8'h00;

	////////////////////////////////////////////////////////////////////////////
	// source rates in hertz
	localparam int PTD_CLK_HZ       = 100_000_000;
	localparam int PTD_SYS_FAST_HZ  = 3_580_000;
	localparam int PTD_FAST_DIV     = 4;
	localparam int PTD_FAST_SRC_HZ  = PTD_SYS_FAST_HZ / PTD_FAST_DIV;
	localparam int PTD_SLOW_SRC_HZ  = 32_768;
	localparam int PTD_PHASE_W      = 32;
	localparam int PTD_PRESCALE_W   = 3;

	////////////////////////////////////////////////////////////////////////////
	// prescaler ratios, values of the two select bits
	typedef enum logic [1:0] {
		PTD_PRES_DIV1 = 2'b00,
		PTD_PRES_DIV2 = 2'b01,
		PTD_PRES_DIV4 = 2'b10,
		PTD_PRES_DIV8 = 2'b11
	} ptd_pres_e;

	// stored upper nibble of divider_control
	typedef struct packed {
		logic      source_clock_select;
		ptd_pres_e prescale_select;
		logic      tone_output_enable;
	} ptd_ctrl_s;

	// one register port request
	typedef struct packed {
		logic [PTD_ADDR_W-1:0] addr;
		logic [PTD_DATA_W-1:0] wdata;
		logic                  wr;
		logic                  rd;
	} ptd_bus_req_s;

endpackage : ptd_pkg

// file: verification/tb_top.sv
// self-checking bench for the programmable tone divider
`timescale 1ns/1ns

module tb_top;
	import ptd_pkg::*;

	localparam int CLK_HZ = 4_000_000;

	logic         clk;
	logic         arst_n;
	ptd_bus_req_s bus_req;
	logic [7:0]   bus_rdata;
	logic         tone_output_pin;
	logic [7:0]   exp_q[$];
	logic         rd_seen;
	logic         low_ok;
	int           failures;
	int           samples_checked;
	int           cyc;
	int           n;
	real          per;

	ptd_divider #(.CLK_HZ(CLK_HZ)) u_ptd_divider (
		.clk             (clk),
		.arst_n          (arst_n),
		.bus_req         (bus_req),
		.bus_rdata       (bus_rdata),
		.tone_output_pin (tone_output_pin)
	);

	////////////////////////////////////////////////////////////////////////////
	// clock
	initial clk = 1'b0;
	always #5 clk = ~clk;

	////////////////////////////////////////////////////////////////////////////
	// shared tasks
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		bus_req.addr  <= a;
		bus_req.wdata <= d;
		bus_req.wr    <= 1'b1;
		@(posedge clk);
		bus_req.wr    <= 1'b0;
	endtask : wr

	// read request; the expected answer is noted for the watcher
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		bus_req.addr <= a;
		bus_req.rd   <= 1'b1;
		exp_q.push_back(e);
		@(posedge clk);
		bus_req.rd   <= 1'b0;
	endtask : rd

	// cycles until the next rising edge of the tone pin, bounded
	task automatic to_rise(output int c);
		c = 0;
		while (tone_output_pin === 1'b1 && c < 20000) begin
			@(posedge clk);
			c++;
		end
		while (tone_output_pin !== 1'b1 && c < 20000) begin
			@(posedge clk);
			c++;
		end
	endtask : to_rise

	task automatic print_verdict();
		$display("checked %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : print_verdict

	////////////////////////////////////////////////////////////////////////////
	// watcher: read data in the cycle after a read, zero otherwise
	always @(posedge clk) begin
		if (rd_seen && exp_q.size() > 0) begin
			check("bus_rdata", {24'h0, bus_rdata}, {24'h0, exp_q.pop_front()});
		end else if (arst_n === 1'b1 && bus_rdata !== 8'h00) begin
			check("bus_rdata_idle", {24'h0, bus_rdata}, 32'h0);
		end
		rd_seen <= bus_req.rd;
	end

	// watchdog against a hang
	initial begin
		#(60_000 * 10);
		failures++;
		print_verdict();
	end

	////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		arst_n = 1'b0;
		bus_req = '0;
		rd_seen = 1'b0;
		failures = 0;
		samples_checked = 0;
		void'($urandom(32'h327c1a4c));
		repeat (10) @(posedge clk);
		arst_n <= 1'b1;
		// reset values and an unmapped place
		rd(PTD_ADDR_DIVIDER_CONTROL, 8'h00);
		rd(PTD_ADDR_DIVIDER_COUNT_VALUE, 8'h00);
		rd(8'h30, 8'h00);
		check("tone_reset", {31'h0, tone_output_pin}, 32'h0);
		$display("test reset done");
		// count writes dropped while off, unmapped write harmless
		wr(PTD_ADDR_DIVIDER_COUNT_VALUE, 8'($urandom()) | 8'h01);
		wr(8'h2d, 8'hff);
		rd(PTD_ADDR_DIVIDER_COUNT_VALUE, 8'h00);
		rd(PTD_ADDR_DIVIDER_CONTROL, 8'h00);
		$display("test refuse done");
		// every upper nibble reads back, low nibble always zero
		for (int v = 0; v < 16; v++) begin
			wr(PTD_ADDR_DIVIDER_CONTROL, {v[3:0], 4'hf});
			rd(PTD_ADDR_DIVIDER_CONTROL, {v[3:0], 4'h0});
		end
		$display("test control done");
		// tone period for each source and prescale ratio
		for (int s = 0; s < 2; s++) begin
			for (int p = 0; p < 4; p++) begin
				n = (s == 1) ? $urandom_range(7, 0) : 0;
				wr(PTD_ADDR_DIVIDER_CONTROL, {s[0], p[1:0], 1'b1, 4'h0});
				wr(PTD_ADDR_DIVIDER_COUNT_VALUE, n[7:0]);
				rd(PTD_ADDR_DIVIDER_COUNT_VALUE, n[7:0]);
				to_rise(cyc);
				to_rise(cyc);
				to_rise(cyc);
				per = 2.0 * (n + 1) * (1 << p) * CLK_HZ
					/ ((s == 1) ? PTD_FAST_SRC_HZ : PTD_SLOW_SRC_HZ);
				check("tone_period", {31'h0, (cyc > per - 3.0) && (cyc < per + 3.0)}, 32'h1);
			end
		end
		$display("test tone done");
		// disable clears count and holds the pin low
		wr(PTD_ADDR_DIVIDER_CONTROL, 8'he0);
		rd(PTD_ADDR_DIVIDER_COUNT_VALUE, 8'h00);
		rd(PTD_ADDR_DIVIDER_CONTROL, 8'he0);
		low_ok = 1'b1;
		repeat (600) begin
			@(posedge clk);
			if (tone_output_pin !== 1'b0) begin
				low_ok = 1'b0;
			end
		end
		check("tone_low", {31'h0, low_ok}, 32'h1);
		wr(PTD_ADDR_DIVIDER_CONTROL, 8'h90);
		rd(PTD_ADDR_DIVIDER_COUNT_VALUE, 8'h00);
		$display("test disable done");
		repeat (3) @(posedge clk);
		print_verdict();
	end

endmodule : tb_top
